/* File: logic/nvb_eeprom.sv */
`timescale 1ns/1ps
`include "nvb_params.svh"
module nvb_eeprom #(
  parameter int unsigned DEPTH        = 512,
  parameter int unsigned AW           = 9,
  parameter int unsigned WRITE_CYCLES = `NVB_WRITE_CYCLES
) (
  input  wire logic            i_clk,
  input  wire logic            i_rst_n,
  input  wire nvb_pkg::nvb_io_s i_io,
  input  wire logic            i_sleep,
  output logic [7:0]           o_rdata,
  output logic                 o_cpu_stall,
  output logic                 o_write_busy
);
  // No reset on the array; unwritten bytes read unknown
  logic [7:0]          mem [DEPTH];
  logic [7:0]          nv_data_reg_ff;
  logic [7:0]          nv_address_low_ff;
  logic [7:0]          nv_address_high_ff;
  logic                nv_write_arm_ff;
  logic                nv_write_strobe_ff;
  logic [2:0]          arm_cnt_ff;
  logic [31:0]         wtime_ff;
  logic [AW-1:0]       waddr_ff;
  logic [7:0]          wbyte_ff;
  logic [7:0]          rdata_ff;
  nvb_pkg::nvb_state_e state_ff;
  logic                ctrl_wr;
  logic                start_wr;
  logic                start_rd;
  logic                stall_load;
  logic [2:0]          stall_len;
  logic [AW-1:0]       cur_addr;
  logic                write_done;

  assign cur_addr = AW'({nv_address_high_ff, nv_address_low_ff});
  assign ctrl_wr  = i_io.wr && (i_io.addr == `NVB_OFS_CTRL);
  // Strobe honoured only while armed and idle
  assign start_wr = ctrl_wr && i_io.wdata[`NVB_BIT_STROBE] &&
                    nv_write_arm_ff && (state_ff == nvb_pkg::ST_IDLE);
  // Reads refused during a write; the array is busy
  assign start_rd = ctrl_wr && i_io.wdata[`NVB_BIT_READ] &&
                    (state_ff == nvb_pkg::ST_IDLE) && !start_wr;
  assign write_done = (state_ff == nvb_pkg::ST_BUSY) && (wtime_ff == 32'h1);

  // Address and data registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      nv_data_reg_ff     <= 8'h00;
      nv_address_low_ff  <= 8'h00;
      nv_address_high_ff <= 8'h00;
    end else if (i_io.wr) begin
      if (i_io.addr == `NVB_OFS_DATA)
        nv_data_reg_ff <= i_io.wdata;
      if (i_io.addr == `NVB_OFS_ADDR_LOW)
        nv_address_low_ff <= i_io.wdata;
      if (i_io.addr == `NVB_OFS_ADDR_HIGH)
        nv_address_high_ff <= i_io.wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      nv_write_arm_ff <= 1'b0;
      arm_cnt_ff      <= 3'h0;
    end else if (ctrl_wr && i_io.wdata[`NVB_BIT_ARM]) begin
      nv_write_arm_ff <= 1'b1;
      arm_cnt_ff      <= `NVB_ARM_WINDOW;
    end else if (start_wr || arm_cnt_ff == 3'h1) begin
      nv_write_arm_ff <= 1'b0;
      arm_cnt_ff      <= 3'h0;
    end else if (arm_cnt_ff != 3'h0) begin
      arm_cnt_ff <= arm_cnt_ff - 3'h1;
    end
  end

  // self-timed write; sleep does not stop it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff           <= nvb_pkg::ST_IDLE;
      nv_write_strobe_ff <= 1'b0;
      wtime_ff           <= 32'h0;
      waddr_ff           <= '0;
      wbyte_ff           <= 8'h00;
    end else if (start_wr) begin
      state_ff           <= nvb_pkg::ST_BUSY;
      nv_write_strobe_ff <= 1'b1;
      wtime_ff           <= WRITE_CYCLES;
      waddr_ff           <= cur_addr;
      wbyte_ff           <= nv_data_reg_ff;
    end else begin
      case (state_ff)
        nvb_pkg::ST_BUSY: begin
          wtime_ff <= wtime_ff - 32'h1;
          if (write_done) begin
            state_ff           <= nvb_pkg::ST_IDLE;
            nv_write_strobe_ff <= 1'b0;
          end
        end
        default: state_ff <= nvb_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (write_done)
      mem[waddr_ff] <= wbyte_ff;
  end

  // read byte lands in the data path
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_ff <= 8'h00;
    end else if (start_rd) begin
      rdata_ff <= mem[cur_addr];
    end else if (i_io.rd) begin
      case (i_io.addr)
        `NVB_OFS_CTRL:      rdata_ff <= {5'h00, nv_write_arm_ff,
                                         nv_write_strobe_ff, 1'b0};
        `NVB_OFS_DATA:      rdata_ff <= nv_data_reg_ff;
        `NVB_OFS_ADDR_LOW:  rdata_ff <= nv_address_low_ff;
        `NVB_OFS_ADDR_HIGH: rdata_ff <= nv_address_high_ff;
        default:            rdata_ff <= 8'h00;
      endcase
    end
  end

  // four-cycle read stall; two-cycle write stall
  assign stall_load = start_rd || start_wr;
  assign stall_len  = start_rd ? `NVB_READ_STALL : `NVB_WRITE_STALL;

  nvb_stall u_stall (
    .i_clk    (i_clk),
    .i_rst_n  (i_rst_n),
    .i_load   (stall_load),
    .i_cycles (stall_len),
    .o_stall  (o_cpu_stall)
  );

  assign o_rdata      = rdata_ff;
  assign o_write_busy = nv_write_strobe_ff;

  // Assertions
  // read stall length
  read_stall_len_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    start_rd |=> o_cpu_stall [*4] ##1 !o_cpu_stall)
    else $error("read stall not four cycles");
  write_stall_len_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    start_wr |=> o_cpu_stall [*2] ##1 !o_cpu_stall)
    else $error("write stall not two cycles");
  busy_on_start_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    start_wr |=> o_write_busy && state_ff == nvb_pkg::ST_BUSY)
    else $error("busy not set on write start");
  sleep_runs_on_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (o_write_busy && i_sleep && wtime_ff > 32'h1)
      |=> o_write_busy && wtime_ff == $past(wtime_ff) - 32'h1)
    else $error("write halted in sleep");
  strobe_clear_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    write_done |=> !o_write_busy)
    else $error("strobe not cleared at write end");
  arm_timeout_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (ctrl_wr && i_io.wdata[`NVB_BIT_ARM]) |-> ##[1:5] !nv_write_arm_ff)
    else $error("arm bit did not self clear");
  no_strobe_unarmed_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_write_busy) |-> $past(nv_write_arm_ff))
    else $error("write started without arm");
  unarmed_ignored_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (ctrl_wr && i_io.wdata[`NVB_BIT_STROBE] && !nv_write_arm_ff)
      |=> !$rose(o_write_busy))
    else $error("unarmed strobe started a write");
  byte_captured_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    start_wr |=> wbyte_ff == $past(nv_data_reg_ff)
      && waddr_ff == $past(cur_addr))
    else $error("write byte or address not captured");
  write_lands_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    write_done |=> mem[$past(waddr_ff)] == $past(wbyte_ff))
    else $error("written byte not in array");
  status_read_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_io.rd && i_io.addr == `NVB_OFS_CTRL && !start_rd)
      |=> o_rdata[`NVB_BIT_STROBE] == $past(o_write_busy))
    else $error("status bit read back wrong");

  read_cov_c:  cover property (@(posedge i_clk) start_rd);
  write_cov_c: cover property (@(posedge i_clk) start_wr);
  done_cov_c:  cover property (@(posedge i_clk) write_done);
  sleep_cov_c: cover property (@(posedge i_clk) o_write_busy && i_sleep);
  lapse_cov_c: cover property (@(posedge i_clk) arm_cnt_ff == 3'h1);
endmodule

/* File: logic/nvb_params.svh */
`ifndef NVB_PARAMS_SVH
`define NVB_PARAMS_SVH
// I/O-space offsets of the access registers
`define NVB_OFS_CTRL      6'h1f
`define NVB_OFS_DATA      6'h20
`define NVB_OFS_ADDR_LOW  6'h21
`define NVB_OFS_ADDR_HIGH 6'h22
// Control register bit positions
`define NVB_BIT_READ      0
`define NVB_BIT_STROBE    1
`define NVB_BIT_ARM       2
// Stall lengths in clock cycles
`define NVB_READ_STALL    3'h4
`define NVB_WRITE_STALL   3'h2
// Arm window in cycles
`define NVB_ARM_WINDOW    3'h4
// Write access time in us and derived cycles at 100 MHz
`define NVB_WRITE_TIME_US 9000
`define NVB_CLK_MHZ       100
`define NVB_WRITE_CYCLES  (`NVB_WRITE_TIME_US * `NVB_CLK_MHZ)
`endif

/* File: logic/nvb_pkg.sv */
package nvb_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } nvb_io_s;
  typedef enum logic [1:0] {ST_IDLE, ST_BUSY} nvb_state_e;
endpackage

/* File: logic/nvb_stall.sv */
`timescale 1ns/1ps
// Loads a count and holds the stall output until it runs out
module nvb_stall (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_load,
  input  wire logic [2:0] i_cycles,
  output logic            o_stall
);
  logic [2:0] cnt_ff;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff <= 3'h0;
    end else if (i_load) begin
      cnt_ff <= i_cycles;
    end else if (cnt_ff != 3'h0) begin
      cnt_ff <= cnt_ff - 3'h1;
    end
  end
  assign o_stall = (cnt_ff != 3'h0);
endmodule

/* File: test/nvb_cpu_model.sv */
`timescale 1ns/1ps
`include "nvb_params.svh"
// CPU side of the I/O register bus
module nvb_cpu_model (
  input  wire logic        i_clk,
  input  wire logic        i_busy,
  output nvb_pkg::nvb_io_s o_io
);
  initial o_io = '0;
  // Held over one edge; back-to-back calls keep the strobe up
  task automatic io_op(input logic rd, input logic [5:0] a,
                       input logic [7:0] d);
    o_io = '{wr: !rd, rd: rd, addr: a, wdata: d};
    @(posedge i_clk) #1;
  endtask
  // Idle bus shows inverted values so stale data never looks valid
  task automatic io_idle;
    o_io = '{wr: 1'b0, rd: 1'b0, addr: ~o_io.addr, wdata: ~o_io.wdata};
  endtask
  task automatic nv_write(input logic [8:0] a, input logic [7:0] d,
                          input bit late, output bit hung);
    for (int i = 0; i < 1000 && i_busy !== 1'b0; i++) @(posedge i_clk) #1;
    hung = (i_busy !== 1'b0);
    io_op(1'b0, `NVB_OFS_ADDR_HIGH, {7'h00, a[8]});
    io_op(1'b0, `NVB_OFS_ADDR_LOW, a[7:0]);
    io_op(1'b0, `NVB_OFS_DATA, d);
    io_op(1'b0, `NVB_OFS_CTRL, 8'h04);
    if (late) begin
      io_idle();
      repeat (6) @(posedge i_clk) #1;
    end
    io_op(1'b0, `NVB_OFS_CTRL, 8'h02);
    io_idle();
  endtask
endmodule

/* File: test/testbench.sv */
`timescale 1ns/1ps
`include "nvb_params.svh"
module testbench;
  localparam int WC = 20;
  logic             i_clk;
  logic             i_rst_n;
  logic             i_sleep;
  nvb_pkg::nvb_io_s cpu_io;
  logic [7:0]       o_rdata;
  logic             o_cpu_stall;
  logic             o_write_busy;
  int               bad_count;
  int               check_count;
  logic [7:0]       mem [int];
  nvb_eeprom #(.WRITE_CYCLES(WC)) u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_io(cpu_io), .i_sleep(i_sleep), .o_rdata(o_rdata),
    .o_cpu_stall(o_cpu_stall), .o_write_busy(o_write_busy));
  nvb_cpu_model u_cpu (.i_clk(i_clk), .i_busy(o_write_busy), .o_io(cpu_io));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t byte %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkn(input int got, input int exp);
    check_count++;
    if (got != exp) begin
      bad_count++;
      $display("BAD %0t count %0d exp %0d", $time, got, exp);
    end
  endtask
  task automatic hang;
    bad_count++;
    $display("BAD %0t wait ran out", $time);
    complete_run();
  endtask
  // Stall and busy overlap, so both are counted in one pass
  task automatic watch(output int s, output int b);
    int n;
    s = 0;
    b = 0;
    n = 0;
    do begin
      s += (o_cpu_stall === 1'b1);
      b += (o_write_busy === 1'b1);
      n++;
      if (n > 3 * WC) hang();
      @(posedge i_clk) #1;
    end while (o_cpu_stall !== 1'b0 || o_write_busy !== 1'b0);
  endtask
  task automatic wr_chk(input logic [8:0] a, input logic [7:0] d,
                        input bit late);
    int s, b;
    bit hung;
    u_cpu.nv_write(a, d, late, hung);
    if (hung) hang();
    watch(s, b);
    chkn(s, late ? 0 : 2);
    chkn(b, late ? 0 : WC);
    if (!late) mem[a] = d;
  endtask
  task automatic rd_chk(input logic [8:0] a);
    int s, b;
    u_cpu.io_op(1'b0, `NVB_OFS_ADDR_HIGH, {7'h00, a[8]});
    u_cpu.io_op(1'b0, `NVB_OFS_ADDR_LOW, a[7:0]);
    u_cpu.io_op(1'b0, `NVB_OFS_CTRL, 8'h01);
    u_cpu.io_idle();
    watch(s, b);
    chkn(s, 4);
    chk8(o_rdata, mem[a]);
  endtask
  initial begin
    logic [8:0] a;
    logic [7:0] d;
    i_rst_n = 1'b0;
    i_sleep = 1'b0;
    bad_count = 0;
    check_count = 0;
    void'($urandom(32'hb223));
    repeat (6) @(posedge i_clk);
    #1 i_rst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      a = 9'($urandom);
      d = 8'($urandom);
      wr_chk(a, d, 1'b0);
      rd_chk(a);
    end
    $display("test random bytes done");
    wr_chk(a, ~d, 1'b1);
    rd_chk(a);
    u_cpu.io_op(1'b0, `NVB_OFS_CTRL, 8'h02);
    u_cpu.io_idle();
    @(posedge i_clk) #1;
    chk8({7'h00, o_write_busy}, 8'h00);
    $display("test write guard done");
    i_sleep = 1'b1;
    wr_chk(9'h1ff, 8'h5a, 1'b0);
    i_sleep = 1'b0;
    rd_chk(9'h1ff);
    u_cpu.io_op(1'b1, `NVB_OFS_CTRL, 8'h00);
    u_cpu.io_idle();
    chk8(o_rdata & 8'h02, 8'h00);
    $display("test sleep write done");
    complete_run();
  end
endmodule
